// *** design/src_match_pkg.sv ***
package src_match_pkg;
    // table placement and geometry
    localparam logic [15:0] TABLE_BASE = 16'h6100;
    localparam int TABLE_BYTES = 96;
    localparam int SHORT_ENTRIES = 24;
    localparam int EXT_ENTRIES = 12;
    localparam int SHORT_ENTRY_BYTES = 4;
    localparam int EXT_ENTRY_BYTES = 8;
    localparam int VEC_W = 24;
    localparam int IDX_W = 7;
    localparam int CNT_W = 5;

    // result index fields
    localparam logic [6:0] IDX_NONE = 7'h3F;
    localparam int IDX_EXT_BIT = 5;
    localparam int IDX_PEND_BIT = 6;

    // source address modes of the frame control field
    localparam logic [1:0] MODE_SHORT = 2'h2;
    localparam logic [1:0] MODE_EXT = 2'h3;

    // reset values
    localparam logic MATCH_EN_RESET = 1'b1;
    localparam logic [23:0] VEC_RESET = 24'h00_0000;

    // timing at the 100 MHz core clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int RX_GAP_US = 192;
    localparam int RX_GAP_CYCLES = (RX_GAP_US * 1000) / CLK_PERIOD_NS;

    // matcher sequence, gray along idle-scan-eval-done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_EVAL = 2'b11,
        ST_DONE = 2'b10
    } match_state_t;
endpackage : src_match_pkg

// *** design/rx_source_address_matcher.sv ***
`timescale 1ns/1ps
module rx_source_address_matcher #(
    parameter int RX_GAP_CYCLES = src_match_pkg::RX_GAP_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // table writes from the radio ram port
    input wire logic table_wr_i,
    input wire logic [15:0] table_addr_i,
    input wire logic [7:0] table_wdata_i,
    // match control register
    input wire logic match_control_wr_i,
    input wire logic match_enable_wdata_i,
    input wire logic auto_pending_wdata_i,
    output logic match_enable_o,
    output logic auto_pending_en_o,
    // enable vectors
    input wire logic [23:0] short_entry_enable_vec_i,
    input wire logic [23:0] ext_entry_enable_vec_i,
    input wire logic [23:0] short_pending_enable_vec_i,
    input wire logic [23:0] ext_pending_enable_vec_i,
    output logic [23:0] ext_entry_enable_rd_o,
    // frame filter side
    input wire logic frame_filter_en_i,
    input wire logic frame_accepted_event_i,
    input wire logic pend_datareq_ok_i,
    input wire logic [1:0] src_addr_mode_i,
    input wire logic [15:0] src_panid_i,
    input wire logic [15:0] src_short_i,
    input wire logic [63:0] src_ext_i,
    // results
    output logic [23:0] match_result_mask_o,
    output logic [6:0] match_result_index_o,
    output logic result_wr_o,
    output logic match_done_flag_o,
    output logic match_found_flag_o,
    // status word appended in place of the fcs
    input wire logic auto_checksum_en_i,
    input wire logic append_select_i,
    input wire logic eight_symbols_i,
    input wire logic [7:0] rssi_i,
    input wire logic [6:0] correlation_i,
    input wire logic frame_end_i,
    input wire logic fcs_ok_i,
    output logic fcs_drop_o,
    output logic status_valid_o,
    output logic [7:0] status_byte0_o,
    output logic [7:0] status_byte1_o,
    // receive turnaround
    input wire logic rx_turnaround_disable_i,
    output logic rx_gap_busy_o
);
    localparam int GAP_W = $clog2(RX_GAP_CYCLES + 1);

    generate
        if (RX_GAP_CYCLES < 1) begin : g_bad_gap
            $error("RX_GAP_CYCLES must be at least one");
        end
    endgenerate

    // read one little-endian byte group out of the table
    function automatic logic [15:0] rd16(input logic [7:0] tbl [src_match_pkg::TABLE_BYTES], input int base);
        rd16 = {tbl[base + 1], tbl[base]};
    endfunction : rd16

    // spread each extended bit 2n onto 2n+1
    function automatic logic [23:0] mirror_ext(input logic [23:0] v);
        logic [23:0] r;
        r = '0;
        for (int i = 0; i < src_match_pkg::EXT_ENTRIES; i++) begin
            r[2*i] = v[2*i];
            r[2*i+1] = v[2*i];
        end
        mirror_ext = r;
    endfunction : mirror_ext

    // position of lowest set bit
    function automatic logic [4:0] lowest_bit(input logic [23:0] v);
        logic [4:0] r;
        r = '0;
        for (int i = src_match_pkg::VEC_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        lowest_bit = r;
    endfunction : lowest_bit

    logic [7:0] table_mem [src_match_pkg::TABLE_BYTES];
    src_match_pkg::match_state_t state_ff, nxt_state;
    logic match_en_ff;
    logic auto_pend_ff;
    logic is_ext_ff;
    logic [4:0] cnt_ff;
    logic [23:0] hit_ff;
    logic [23:0] en_ff;
    logic [15:0] panid_ff;
    logic [15:0] short_ff;
    logic [63:0] ext_ff;
    logic [23:0] mask_ff;
    logic [6:0] index_ff;
    logic found_ff;
    logic done_ff;
    logic wr_ff;
    logic [7:0] rssi_ff;
    logic [6:0] corr_ff;
    logic status_valid_ff;
    logic [7:0] byte0_ff;
    logic [7:0] byte1_ff;
    logic [GAP_W-1:0] gap_ff;

    // table decode: a write lands only inside the 96-byte window
    wire [15:0] tbl_off = table_addr_i - src_match_pkg::TABLE_BASE;
    wire tbl_hit = table_wr_i && (table_addr_i >= src_match_pkg::TABLE_BASE)
        && (tbl_off < 16'(src_match_pkg::TABLE_BYTES));

    // frame start decode
    wire start_ok = frame_accepted_event_i && frame_filter_en_i && match_en_ff;
    wire has_addr = (src_addr_mode_i == src_match_pkg::MODE_SHORT)
        || (src_addr_mode_i == src_match_pkg::MODE_EXT);
    wire is_ext_now = (src_addr_mode_i == src_match_pkg::MODE_EXT);
    wire [23:0] ext_en_mirror = mirror_ext(ext_entry_enable_vec_i);
    wire [23:0] en_sel = is_ext_ff ? ext_en_mirror : short_entry_enable_vec_i;

    // compare of the entry under the scan counter
    wire [6:0] sbase = 7'(cnt_ff * src_match_pkg::SHORT_ENTRY_BYTES);
    wire [6:0] ebase = 7'(cnt_ff * src_match_pkg::EXT_ENTRY_BYTES);
    wire short_eq = (rd16(table_mem, int'(sbase)) == panid_ff)
        && (rd16(table_mem, int'(sbase) + 2) == short_ff);
    wire ext_eq = {rd16(table_mem, int'(ebase) + 6), rd16(table_mem, int'(ebase) + 4),
        rd16(table_mem, int'(ebase) + 2), rd16(table_mem, int'(ebase))} == ext_ff;
    wire [4:0] last_cnt = is_ext_ff ? 5'(src_match_pkg::EXT_ENTRIES - 1) : 5'(src_match_pkg::SHORT_ENTRIES - 1);
    wire scan_last = (cnt_ff == last_cnt);

    // result forming: only hits on entries enabled the whole way count
    wire [23:0] final_mask = hit_ff & en_ff;
    wire any_hit = |final_mask;
    wire [4:0] low_pos = lowest_bit(final_mask);
    wire [23:0] pend_sel = is_ext_ff ? mirror_ext(ext_pending_enable_vec_i) : short_pending_enable_vec_i;
    wire pend_hit = auto_pend_ff && frame_filter_en_i && match_en_ff && pend_datareq_ok_i
        && |(final_mask & pend_sel);
    wire [4:0] entry_num = is_ext_ff ? {1'b0, low_pos[4:1]} : low_pos;
    wire [6:0] nxt_index = any_hit ? {pend_hit, is_ext_ff, entry_num}
        : src_match_pkg::IDX_NONE;

    // table storage, software owned
    always_ff @(posedge core_clk_i) begin
        if (tbl_hit) begin
            table_mem[tbl_off[6:0]] <= table_wdata_i;
        end
    end

    // match control register
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            match_en_ff <= src_match_pkg::MATCH_EN_RESET;
            auto_pend_ff <= 1'b0;
        end else if (match_control_wr_i) begin
            match_en_ff <= match_enable_wdata_i;
            auto_pend_ff <= auto_pending_wdata_i;
        end
    end

    // sequence: a frame with no source address skips the scan
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            src_match_pkg::ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = has_addr ? src_match_pkg::ST_SCAN : src_match_pkg::ST_EVAL;
                end
            end
            src_match_pkg::ST_SCAN: begin
                if (scan_last) begin
                    nxt_state = src_match_pkg::ST_EVAL;
                end
            end
            src_match_pkg::ST_EVAL: nxt_state = src_match_pkg::ST_DONE;
            src_match_pkg::ST_DONE: nxt_state = src_match_pkg::ST_IDLE;
            default: nxt_state = src_match_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= src_match_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // frame capture and scan bookkeeping; enable mask is reloaded in idle and only loses bits during the scan
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
            hit_ff <= src_match_pkg::VEC_RESET;
            en_ff <= src_match_pkg::VEC_RESET;
            is_ext_ff <= 1'b0;
            panid_ff <= '0;
            short_ff <= '0;
            ext_ff <= '0;
        end else if (state_ff == src_match_pkg::ST_IDLE) begin
            cnt_ff <= '0;
            hit_ff <= src_match_pkg::VEC_RESET;
            en_ff <= is_ext_now ? ext_en_mirror : short_entry_enable_vec_i;
            if (start_ok) begin
                is_ext_ff <= is_ext_now;
                panid_ff <= src_panid_i;
                short_ff <= src_short_i;
                ext_ff <= src_ext_i;
            end
        end else if (state_ff == src_match_pkg::ST_SCAN) begin
            cnt_ff <= cnt_ff + 5'd1;
            en_ff <= en_ff & en_sel;
            if (!is_ext_ff && short_eq) begin
                hit_ff[cnt_ff] <= 1'b1;
            end
            if (is_ext_ff && ext_eq) begin
                hit_ff[{cnt_ff[3:0], 1'b0}] <= 1'b1;
                hit_ff[{cnt_ff[3:0], 1'b1}] <= 1'b1;
            end
        end
    end

    // results and flags: found in eval, done one cycle later
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mask_ff <= src_match_pkg::VEC_RESET;
            index_ff <= src_match_pkg::IDX_NONE;
            found_ff <= 1'b0;
            done_ff <= 1'b0;
            wr_ff <= 1'b0;
        end else begin
            found_ff <= (state_ff == src_match_pkg::ST_EVAL) && any_hit;
            done_ff <= (state_ff == src_match_pkg::ST_DONE);
            wr_ff <= (state_ff == src_match_pkg::ST_EVAL);
            if (state_ff == src_match_pkg::ST_EVAL) begin
                mask_ff <= final_mask;
                index_ff <= nxt_index;
            end
        end
    end

    // rssi and correlation caught once eight symbols have passed
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rssi_ff <= '0;
            corr_ff <= '0;
        end else if (eight_symbols_i) begin
            rssi_ff <= rssi_i;
            corr_ff <= correlation_i;
        end
    end

    // status word built at frame end; index replaces link quality when asked
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            status_valid_ff <= 1'b0;
            byte0_ff <= '0;
            byte1_ff <= '0;
        end else begin
            status_valid_ff <= frame_end_i && auto_checksum_en_i;
            if (frame_end_i && auto_checksum_en_i) begin
                byte0_ff <= rssi_ff;
                byte1_ff <= {fcs_ok_i, append_select_i ? index_ff : corr_ff};
            end
        end
    end

    // extra receive gap after a frame when turnaround is not disabled
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            gap_ff <= '0;
        end else if (frame_end_i && !rx_turnaround_disable_i) begin
            gap_ff <= GAP_W'(RX_GAP_CYCLES);
        end else if (gap_ff != '0) begin
            gap_ff <= gap_ff - GAP_W'(1);
        end
    end

    // outputs; software must disable an entry while rewriting it
    assign match_enable_o = match_en_ff;
    assign auto_pending_en_o = auto_pend_ff;
    assign ext_entry_enable_rd_o = ext_en_mirror;
    assign match_result_mask_o = mask_ff;
    assign match_result_index_o = index_ff;
    assign result_wr_o = wr_ff;
    assign match_done_flag_o = done_ff;
    assign match_found_flag_o = found_ff;
    assign fcs_drop_o = auto_checksum_en_i;
    assign status_valid_o = status_valid_ff;
    assign status_byte0_o = byte0_ff;
    assign status_byte1_o = byte1_ff;
    assign rx_gap_busy_o = (gap_ff != '0);

    // checks
    property p_found_before_done;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        match_found_flag_o |=> match_done_flag_o;
    endproperty
    a_found_before_done: assert property (p_found_before_done) else $error("found not followed by done");
    property p_done_after_start;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == src_match_pkg::ST_IDLE && start_ok) |-> ##[2:27] match_done_flag_o;
    endproperty
    a_done_after_start: assert property (p_done_after_start) else $error("done missing after start");
    property p_no_start_unfiltered;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == src_match_pkg::ST_IDLE && !(frame_filter_en_i && match_en_ff)) |=>
            state_ff == src_match_pkg::ST_IDLE;
    endproperty
    a_no_start_unfiltered: assert property (p_no_start_unfiltered) else $error("match started unfiltered");
    property p_none_index;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (result_wr_o && match_result_mask_o == '0) |-> match_result_index_o == 7'h3F;
    endproperty
    a_none_index: assert property (p_none_index) else $error("no-match index wrong");
    property p_found_mask;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        match_found_flag_o |-> (match_result_mask_o != '0 && match_result_index_o[4:0] < 5'd24);
    endproperty
    a_found_mask: assert property (p_found_mask) else $error("found without mask");
    property p_ext_pairs;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (result_wr_o && match_result_index_o[5] && match_result_index_o != 7'h3F) |->
            match_result_mask_o == mirror_ext(match_result_mask_o);
    endproperty
    a_ext_pairs: assert property (p_ext_pairs) else $error("extended mask not paired");
    property p_mirror_read;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ext_entry_enable_rd_o[1] == ext_entry_enable_vec_i[0];
    endproperty
    a_mirror_read: assert property (p_mirror_read) else $error("odd enable bit not mirrored");
    property p_gap_length;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (frame_end_i && !rx_turnaround_disable_i) |=> rx_gap_busy_o [*8];
    endproperty
    a_gap_length: assert property (p_gap_length) else $error("turnaround gap too short");
    property p_status_word;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (frame_end_i && auto_checksum_en_i && append_select_i) |=>
            status_valid_o && status_byte1_o == {$past(fcs_ok_i), $past(index_ff)};
    endproperty
    a_status_word: assert property (p_status_word) else $error("status word wrong");
endmodule : rx_source_address_matcher

// *** tb/frame_source_model.sv ***
`timescale 1ns/1ps
// stands in for the frame filter and demodulator in front of the matcher
module frame_source_model (
    input wire logic core_clk_i,
    output logic frame_accepted_event_o,
    output logic [1:0] src_addr_mode_o,
    output logic [15:0] src_panid_o,
    output logic [15:0] src_short_o,
    output logic [63:0] src_ext_o,
    output logic eight_symbols_o,
    output logic [7:0] rssi_o,
    output logic [6:0] correlation_o,
    output logic frame_end_o,
    output logic fcs_ok_o
);
    // quiet lines at time zero
    initial begin
        {frame_accepted_event_o, eight_symbols_o, frame_end_o, fcs_ok_o} = 4'h0;
        {src_addr_mode_o, src_panid_o, src_short_o, src_ext_o} = '0;
        {rssi_o, correlation_o} = '0;
    end

    // fields are only good at the accept edge, so they are scrambled right after
    task automatic accept_frame(input logic [1:0] m, input logic [15:0] p, input logic [15:0] s, input logic [63:0] e);
        @(negedge core_clk_i);
        frame_accepted_event_o = 1'b1;
        {src_addr_mode_o, src_panid_o, src_short_o, src_ext_o} = {m, p, s, e};
        @(negedge core_clk_i);
        frame_accepted_event_o = 1'b0;
        {src_addr_mode_o, src_panid_o, src_short_o, src_ext_o} = ~{m, p, s, e};
    endtask : accept_frame

    // signal strength and correlation after the first eight symbols
    task automatic measure(input logic [7:0] r, input logic [6:0] c);
        @(negedge core_clk_i);
        eight_symbols_o = 1'b1;
        {rssi_o, correlation_o} = {r, c};
        @(negedge core_clk_i);
        eight_symbols_o = 1'b0;
        {rssi_o, correlation_o} = ~{r, c};
    endtask : measure

    // last byte of the frame with its checksum verdict
    task automatic finish_frame(input logic ok);
        @(negedge core_clk_i);
        frame_end_o = 1'b1;
        fcs_ok_o = ok;
        @(negedge core_clk_i);
        frame_end_o = 1'b0;
        fcs_ok_o = ~ok;
    endtask : finish_frame
endmodule : frame_source_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam int GAP = 20;
    logic clk = 1'b0, rst_n = 1'b0, table_wr = 1'b0, ctl_wr = 1'b0, en_wdata = 1'b0, pend_wdata = 1'b0;
    logic filt_en = 1'b1, pend_ok = 1'b1, crc_en = 1'b1, app_sel = 1'b1, ta_dis = 1'b1;
    logic [15:0] table_addr = 16'h0000;
    logic [7:0] table_wdata = 8'h00;
    logic [23:0] short_en = '0, ext_en = '0, short_pend = '0, ext_pend = '0;
    logic [23:0] ext_rd, mask;
    logic [7:0] rssi, sb0, sb1;
    logic [6:0] corr, index;
    logic match_en, pend_en, res_wr, done, found, eight, fend, fok, drop, stat_v, gap_busy, acc;
    logic [1:0] mode;
    logic [15:0] panid, short_a;
    logic [63:0] ext;
    int error_cnt = 0;
    int samples_checked = 0;

    rx_source_address_matcher #(.RX_GAP_CYCLES(GAP)) dut_u (
        .core_clk_i(clk), .rst_n_i(rst_n), .table_wr_i(table_wr), .table_addr_i(table_addr),
        .table_wdata_i(table_wdata), .match_control_wr_i(ctl_wr), .match_enable_wdata_i(en_wdata),
        .auto_pending_wdata_i(pend_wdata), .match_enable_o(match_en), .auto_pending_en_o(pend_en),
        .short_entry_enable_vec_i(short_en), .ext_entry_enable_vec_i(ext_en),
        .short_pending_enable_vec_i(short_pend), .ext_pending_enable_vec_i(ext_pend),
        .ext_entry_enable_rd_o(ext_rd), .frame_filter_en_i(filt_en), .frame_accepted_event_i(acc),
        .pend_datareq_ok_i(pend_ok), .src_addr_mode_i(mode), .src_panid_i(panid), .src_short_i(short_a),
        .src_ext_i(ext), .match_result_mask_o(mask), .match_result_index_o(index), .result_wr_o(res_wr),
        .match_done_flag_o(done), .match_found_flag_o(found), .auto_checksum_en_i(crc_en),
        .append_select_i(app_sel), .eight_symbols_i(eight), .rssi_i(rssi), .correlation_i(corr),
        .frame_end_i(fend), .fcs_ok_i(fok), .fcs_drop_o(drop), .status_valid_o(stat_v),
        .status_byte0_o(sb0), .status_byte1_o(sb1), .rx_turnaround_disable_i(ta_dis), .rx_gap_busy_o(gap_busy)
    );

    frame_source_model partner_u (
        .core_clk_i(clk), .frame_accepted_event_o(acc), .src_addr_mode_o(mode), .src_panid_o(panid),
        .src_short_o(short_a), .src_ext_o(ext), .eight_symbols_o(eight), .rssi_o(rssi),
        .correlation_o(corr), .frame_end_o(fend), .fcs_ok_o(fok)
    );

    // 100 MHz core clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // strobe held high over consecutive bytes, one byte per edge, lsb first
    task automatic wr_bytes(input logic [15:0] addr, input logic [63:0] val, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            table_wr = 1'b1;
            table_addr = addr + 16'(i);
            table_wdata = val[8*i +: 8];
        end
        @(negedge clk);
        table_wr = 1'b0;
    endtask : wr_bytes

    task automatic put_short(input int n, input logic [15:0] p, input logic [15:0] s);
        wr_bytes(src_match_pkg::TABLE_BASE + 16'(4 * n), {32'h0000_0000, s, p}, 4);
    endtask : put_short

    task automatic ctl(input logic en, input logic pend);
        @(negedge clk);
        ctl_wr = 1'b1;
        en_wdata = en;
        pend_wdata = pend;
        @(negedge clk);
        ctl_wr = 1'b0;
    endtask : ctl

    // one frame through the matcher; a value seen just after edge k is sampled at edge k+1,
    // so latencies count sampling edges from the accept edge; lat 0 means no run
    task automatic run_match(input logic [1:0] m, input logic [15:0] p, input logic [15:0] s,
                             input logic [63:0] e, input logic [23:0] exp_mask, input logic [6:0] exp_idx,
                             input int lat);
        int d_lat, f_lat, w_lat;
        d_lat = 0;
        f_lat = 0;
        w_lat = 0;
        partner_u.accept_frame(m, p, s, e);
        for (int i = 2; i <= 41; i++) begin
            @(negedge clk);
            if (found === 1'b1) f_lat = i;
            if (res_wr === 1'b1) w_lat = i;
            if (done === 1'b1) d_lat = i;
        end
        chk("done cycle", d_lat, lat);
        chk("found cycle", f_lat, (exp_idx !== src_match_pkg::IDX_NONE && lat > 0) ? lat - 1 : 0);
        chk("write cycle", w_lat, (lat > 0) ? lat - 1 : 0);
        chk("result mask", mask, exp_mask);
        chk("result index", index, exp_idx);
    endtask : run_match

    // the status pulse stands only in the cycle right after frame end, when finish_frame returns
    task automatic status_check(input logic ok, input logic [7:0] b1);
        partner_u.finish_frame(ok);
        chk("status valid", stat_v, 1);
        chk("status byte0", sb0, 8'h9C);
        chk("status byte1", sb1, b1);
        @(negedge clk);
        chk("status pulse", stat_v, 0);
    endtask : status_check

    // watchdog, well beyond the roughly 550 cycles the sequence needs
    initial begin
        #60000;
        error_cnt++;
        end_sim();
    end

    initial begin
        int busy_n;
        int stat_n;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk("enable at reset", match_en, 1);
        chk("pending at reset", pend_en, 0);
        chk("index at reset", index, src_match_pkg::IDX_NONE);
        // short entries: 1 has the wrong pan id, 5 the wrong address
        put_short(1, 16'h4321, 16'hBEEF);
        put_short(3, 16'h1234, 16'hBEEF);
        // a write past the table end must not wrap onto entry 3
        put_short(35, 16'h0000, 16'h0000);
        put_short(5, 16'h1234, 16'hBEE0);
        put_short(7, 16'h1234, 16'hBEEF);
        put_short(9, 16'h1234, 16'hBEEF);
        wr_bytes(src_match_pkg::TABLE_BASE + 16'd64, 64'h0102_0304_0506_0708, 8);
        wr_bytes(src_match_pkg::TABLE_BASE + 16'd88, 64'h0102_0304_0506_0708, 8);
        short_en = 24'h00_00AA;
        run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0088, 7'h03, 27);
        ctl(1'b1, 1'b1);
        chk("pending set", pend_en, 1);
        short_pend = 24'h00_0020;
        run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0088, 7'h03, 27);
        short_pend = 24'h00_0080;
        run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0088, 7'h43, 27);
        // a frame outside the data-request setting gets no pending bit
        pend_ok = 1'b0;
        run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0088, 7'h03, 27);
        pend_ok = 1'b1;
        // entry 3 dropped and entry 9 raised while the scan runs
        fork
            run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0080, 7'h47, 27);
            begin
                repeat (6) @(negedge clk);
                short_en = 24'h00_02A2;
            end
        join
        short_en = 24'h00_0000;
        ext_en = 24'h41_0002;
        ext_pend = 24'h40_0000;
        @(negedge clk);
        chk("ext enable read", ext_rd, 24'hC3_0000);
        run_match(2'h3, 16'h0, 16'h0, 64'h0102_0304_0506_0708, 24'hC3_0000, 7'h68, 15);
        partner_u.measure(8'h9C, 7'h55);
        chk("fcs drop on", drop, 1);
        status_check(1'b1, 8'hE8);
        app_sel = 1'b0;
        status_check(1'b0, 8'h55);
        // second reset in mid-run: results, status and control fall back to their reset values
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("mask after reset", mask, 24'h00_0000);
        chk("index after reset", index, src_match_pkg::IDX_NONE);
        chk("status after reset", sb1, 8'h00);
        chk("pending after reset", pend_en, 0);
        run_match(2'h0, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0000, 7'h3F, 3);
        short_en = 24'h00_00AA;
        run_match(2'h2, 16'h1234, 16'h0BAD, 64'h0, 24'h00_0000, 7'h3F, 27);
        ctl(1'b0, 1'b1);
        chk("enable cleared", match_en, 0);
        run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0000, 7'h3F, 0);
        ctl(1'b1, 1'b1);
        filt_en = 1'b0;
        run_match(2'h2, 16'h1234, 16'hBEEF, 64'h0, 24'h00_0000, 7'h3F, 0);
        filt_en = 1'b1;
        // checksum off: no status word, and the turnaround gap runs
        crc_en = 1'b0;
        ta_dis = 1'b0;
        @(negedge clk);
        chk("fcs drop off", drop, 0);
        busy_n = 0;
        stat_n = 0;
        partner_u.finish_frame(1'b1);
        // sample before waiting: the gap is already up when finish_frame returns
        repeat (40) begin
            if (gap_busy === 1'b1) busy_n++;
            if (stat_v === 1'b1) stat_n++;
            @(negedge clk);
        end
        chk("gap cycles", busy_n, GAP);
        chk("status refused", stat_n, 0);
        end_sim();
    end
endmodule : tb_top
